// ==== hw/aofc_output_format.sv ====
// register bank and sample path for the dual converter output format
`timescale 1ns/10ps
`include "aofc_params.svh"
module aofc_output_format
  import aofc_pkg::*;
#(
  parameter int SAMPLE_W = 14
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // register port
  input  wire aofc_bus_type         bus,
  output logic [7:0]                rdata,
  // converter side
  input  wire logic [SAMPLE_W-1:0]  sampleA,
  input  wire logic [SAMPLE_W-1:0]  sampleB,
  input  wire aofc_flags_type       flagsA,
  input  wire aofc_flags_type       flagsB,
  input  wire logic [7:0]           overrangeEvent,
  input  wire logic [1:0]           ctrlBitsPerSample,
  input  wire logic                 sysrefPin,
  input  wire logic                 pllLockPin,
  // output side
  output logic [SAMPLE_W+2:0]       wordA,
  output logic [SAMPLE_W+2:0]       wordB,
  output logic                      laneRateLow,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cbSel1;
  logic [7:0] cbSel2;
  logic [7:0] formatCfg;
  logic [7:0] orClear;
  logic [7:0] orStatus;
  logic [7:0] chOrder;
  logic [7:0] laneRate;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [1:0] sysrefSync;
  logic [1:0] lockSync;
  logic       lockPrev;
  logic       wrHit;

  function automatic logic pickSource(input logic [2:0] sel, input aofc_flags_type f,
                                      input logic sref);
    case (sel)
      `AOFC_SEL_OVR:    pickSource = f.overrange;
      `AOFC_SEL_FAST:   pickSource = f.fastDetect;
      `AOFC_SEL_SYSREF: pickSource = sref;
      default:          pickSource = 1'b0;
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] fmtSample(input logic [SAMPLE_W-1:0] s,
                                                  input logic [7:0] cfg);
    logic [SAMPLE_W-1:0] v;
    v = s;
    if (cfg[1:0] == `AOFC_FMT_OFFSET)
      v[SAMPLE_W-1] = ~v[SAMPLE_W-1];
    if (cfg[`AOFC_BIT_INVERT])
      v = ~v;
    fmtSample = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pins from outside the clock domain
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sysrefSync <= 2'h0;
      lockSync   <= 2'h0;
      lockPrev   <= 1'b0;
    end
    else
    begin
      sysrefSync <= {sysrefSync[0], sysrefPin};
      lockSync   <= {lockSync[0], pllLockPin};
      lockPrev   <= lockSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  assign wrHit = bus.wr;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cbSel1    <= `AOFC_RST_CBSEL1;
      cbSel2    <= `AOFC_RST_CBSEL2;
      formatCfg <= `AOFC_RST_FORMAT;
      orClear   <= `AOFC_RST_ORCLR;
      chOrder   <= `AOFC_RST_CHORDER;
      laneRate  <= `AOFC_RST_LANERATE;
      irqMask   <= 8'h00;
    end
    else if (wrHit)
    begin
      case (bus.addr)
        `AOFC_ADDR_CBSEL1:   cbSel1    <= {5'h00, bus.wdata[2:0]};
        `AOFC_ADDR_CBSEL2:   cbSel2    <= {5'h00, bus.wdata[2:0]};
        `AOFC_ADDR_FORMAT:   formatCfg <= {5'h00, bus.wdata[2:0]};
        `AOFC_ADDR_ORCLR:    orClear   <= bus.wdata;
        `AOFC_ADDR_CHORDER:  chOrder   <= {7'h00, bus.wdata[0]};
        `AOFC_ADDR_LANERATE: laneRate  <= {3'h0, bus.wdata[4], 4'h0};
        `AOFC_ADDR_IRQMASK:  irqMask   <= {6'h00, bus.wdata[1:0]};
        default:             ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky overrange: an event in the clearing cycle keeps the bit set
  genvar n;
  generate
    for (n = 0; n < 8; n++)
    begin : g_or
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          orStatus[n] <= 1'b0;
        else if (overrangeEvent[n])
          orStatus[n] <= 1'b1;
        else if (wrHit && bus.addr == `AOFC_ADDR_ORCLR && bus.wdata[n])
          orStatus[n] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: bit 0 any overrange, bit 1 lock lost
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irqStatus <= 8'h00;
    else
    begin
      if (|overrangeEvent)
        irqStatus[0] <= 1'b1;
      else if (wrHit && bus.addr == `AOFC_ADDR_IRQSTAT && bus.wdata[0])
        irqStatus[0] <= 1'b0;
      if (lockPrev && !lockSync[1])
        irqStatus[1] <= 1'b1;
      else if (wrHit && bus.addr == `AOFC_ADDR_IRQSTAT && bus.wdata[1])
        irqStatus[1] <= 1'b0;
    end
  end

  assign irq = |(irqStatus & {irqMask[7:2], irqMask[1], irqMask[0]});

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        `AOFC_ADDR_CBSEL1:   rdata <= cbSel1;
        `AOFC_ADDR_CBSEL2:   rdata <= cbSel2;
        `AOFC_ADDR_FORMAT:   rdata <= formatCfg;
        `AOFC_ADDR_ORCLR:    rdata <= orClear;
        `AOFC_ADDR_ORSTAT:   rdata <= orStatus;
        `AOFC_ADDR_CHORDER:  rdata <= chOrder;
        `AOFC_ADDR_LANERATE: rdata <= laneRate;
        `AOFC_ADDR_LOCK:     rdata <= {lockSync[1], 7'h00};
        `AOFC_ADDR_IRQSTAT:  rdata <= irqStatus;
        `AOFC_ADDR_IRQMASK:  rdata <= irqMask;
        default:             rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  assign laneRateLow = laneRate[`AOFC_BIT_LANERATE];

  ////////////////////////////////////////////////////////////////////////////
  // output sample words: {data, ctrl bit 0 slot, ctrl bit 1 slot, ctrl bit 2}
  logic                aCb0;
  logic                aCb2;
  logic                bCb0;
  logic                bCb2;
  logic [SAMPLE_W-1:0] chA;
  logic [SAMPLE_W-1:0] chB;
  aofc_flags_type      fA;
  aofc_flags_type      fB;

  always_comb
  begin
    chA = chOrder[0] ? sampleB : sampleA;
    chB = chOrder[0] ? sampleA : sampleB;
    fA  = chOrder[0] ? flagsB : flagsA;
    fB  = chOrder[0] ? flagsA : flagsB;
    aCb0 = (ctrlBitsPerSample == 2'd3) ? pickSource(cbSel1[2:0], fA, sysrefSync[1]) : 1'b0;
    bCb0 = (ctrlBitsPerSample == 2'd3) ? pickSource(cbSel1[2:0], fB, sysrefSync[1]) : 1'b0;
    aCb2 = (ctrlBitsPerSample != 2'd0) ? pickSource(cbSel2[2:0], fA, sysrefSync[1]) : 1'b0;
    bCb2 = (ctrlBitsPerSample != 2'd0) ? pickSource(cbSel2[2:0], fB, sysrefSync[1]) : 1'b0;
  end
  // via pickSource and the count checks above

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wordA <= '0;
      wordB <= '0;
    end
    else
    begin
      wordA <= {fmtSample(chA, formatCfg), aCb0, 1'b0, aCb2};
      wordB <= {fmtSample(chB, formatCfg), bCb0, 1'b0, bCb2};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_clr_write;
    bus.wr && bus.addr == `AOFC_ADDR_ORCLR && bus.wdata[0] && !overrangeEvent[0];
  endsequence

  property p_or_clear;
    @(posedge clk) disable iff (sys_rst) s_clr_write |=> !orStatus[0];
  endproperty
  a_or_clear: assert property (p_or_clear) else $error("overrange not cleared");

  property p_or_set;
    @(posedge clk) disable iff (sys_rst) overrangeEvent[3] |=> orStatus[3];
  endproperty
  a_or_set: assert property (p_or_set) else $error("overrange not set");

  property p_or_hold;
    @(posedge clk) disable iff (sys_rst)
      orStatus[5] && !(bus.wr && bus.addr == `AOFC_ADDR_ORCLR) |=> orStatus[5];
  endproperty
  a_or_hold: assert property (p_or_hold) else $error("overrange lost");

  property p_cb0_gate;
    @(posedge clk) disable iff (sys_rst) ctrlBitsPerSample != 2'd3 |=> !wordA[2];
  endproperty
  a_cb0_gate: assert property (p_cb0_gate) else $error("ctrl bit 0 leaked");

  property p_cb2_gate;
    @(posedge clk) disable iff (sys_rst) ctrlBitsPerSample == 2'd0 |=> !wordB[0];
  endproperty
  a_cb2_gate: assert property (p_cb2_gate) else $error("ctrl bit 2 leaked");

  property p_cb0_zero;
    @(posedge clk) disable iff (sys_rst) cbSel1[2:0] == `AOFC_SEL_ZERO |=> !wordA[2];
  endproperty
  a_cb0_zero: assert property (p_cb0_zero) else $error("tie low broken");

  property p_cb2_ovr;
    @(posedge clk) disable iff (sys_rst)
      cbSel2[2:0] == `AOFC_SEL_OVR && ctrlBitsPerSample == 2'd1 && !chOrder[0]
      |=> wordA[0] == $past(flagsA.overrange);
  endproperty
  a_cb2_ovr: assert property (p_cb2_ovr) else $error("ctrl bit 2 source wrong");

  property p_swap;
    @(posedge clk) disable iff (sys_rst)
      chOrder[0] && formatCfg[2:0] == 3'h1 |=> wordA[SAMPLE_W+2:3] == $past(sampleB);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_invert;
    @(posedge clk) disable iff (sys_rst)
      !chOrder[0] && formatCfg[2:0] == 3'h5 |=> wordA[SAMPLE_W+2:3] == ~$past(sampleA);
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong");

  property p_lock;
    @(posedge clk) disable iff (sys_rst)
      bus.rd && bus.addr == `AOFC_ADDR_LOCK |=> rdata[7] == $past(lockSync[1]) && rdata[6:0] == 7'h00;
  endproperty
  a_lock: assert property (p_lock) else $error("lock status wrong");

  property p_lane;
    @(posedge clk) disable iff (sys_rst)
      bus.wr && bus.addr == `AOFC_ADDR_LANERATE |=> laneRateLow == $past(bus.wdata[4]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane rate bit wrong");

  // an event in the same cycle as the clearing write must win
  property p_or_set_wins;
    @(posedge clk) disable iff (sys_rst)
      overrangeEvent[0] && bus.wr && bus.addr == `AOFC_ADDR_ORCLR && bus.wdata[0]
      |=> orStatus[0];
  endproperty
  a_or_set_wins: assert property (p_or_set_wins) else $error("overrange set lost");

  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst) !bus.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

endmodule

// ==== hw/aofc_params.svh ====
// constants for the converter output format control block
// Function
// - control bit 0 source is chosen by a 3-bit code: 000 zero, 001 overrange, 011 fast detect, 101 system reference.
// - control bit 0 enters the sample word only when three control bits per sample are configured.
// - control bit 2 source uses the same codes as bit 0 and resets to the overrange code.
// - control bit 2 enters the sample word when one, two or three control bits are configured.
// - format field 00 gives offset binary and 01 gives two's complement, which is the reset choice.
// - the invert bit at 0 passes samples unchanged and at 1 inverts them.
// - each of eight clear bits, bit n for converter n, clears that converter's overrange flag when written 1.
// - a read-only byte shows one overrange bit per converter, 1 once an overrange occurred.
// - the swap bit at 1 exchanges the two converter channels at the output.
// - bit 4 of the lane rate register selects the high (0) or low (1) serial rate range.
// - the lock status byte shows serializer lock in bit 7.
`ifndef AOFC_PARAMS_SVH
`define AOFC_PARAMS_SVH
`define AOFC_ADDR_CBSEL1     12'h559
`define AOFC_ADDR_CBSEL2     12'h55A
`define AOFC_ADDR_FORMAT     12'h561
`define AOFC_ADDR_ORCLR      12'h562
`define AOFC_ADDR_ORSTAT     12'h563
`define AOFC_ADDR_CHORDER    12'h564
`define AOFC_ADDR_LANERATE   12'h56E
`define AOFC_ADDR_LOCK       12'h56F
`define AOFC_ADDR_IRQSTAT    12'h570
`define AOFC_ADDR_IRQMASK    12'h571
`define AOFC_RST_CBSEL1      8'h00
`define AOFC_RST_CBSEL2      8'h01
`define AOFC_RST_FORMAT      8'h01
`define AOFC_RST_ORCLR       8'h00
`define AOFC_RST_CHORDER     8'h00
`define AOFC_RST_LANERATE    8'h00
`define AOFC_SEL_ZERO        3'h0
`define AOFC_SEL_OVR         3'h1
`define AOFC_SEL_FAST        3'h3
`define AOFC_SEL_SYSREF      3'h5
`define AOFC_FMT_OFFSET      2'h0
`define AOFC_FMT_TWOS        2'h1
`define AOFC_BIT_INVERT      2
`define AOFC_BIT_LANERATE    4
`define AOFC_BIT_LOCK        7
`endif

// ==== hw/aofc_pkg.sv ====
// types shared by the output format control block
package aofc_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } aofc_bus_type;
  typedef struct packed {
    logic overrange;
    logic fastDetect;
  } aofc_flags_type;
endpackage

// ==== test/tb_top.sv ====
// self-checking bench for the converter output format control block
`timescale 1ns/10ps
`include "aofc_params.svh"
module tb_top;
  import aofc_pkg::*;
  localparam int W = 14;
  logic                 clk, sys_rst, sysrefPin, pllLockPin, chkW, rdLast, wLast;
  logic                 laneRateLow, irq;
  aofc_bus_type         bus;
  aofc_flags_type       flagsA, flagsB;
  logic [7:0]           rdata, overrangeEvent, c1, c2, fm, sw;
  logic [1:0]           ctrlBitsPerSample;
  logic [W-1:0]         sampleA, sampleB;
  logic [W+2:0]         wordA, wordB;
  logic [7:0]           rdQueue[$];
  logic [2*W+5:0]       wQueue[$];
  int                   errCount, samplesChecked, seed;
  logic [2:0]           codes[4] = '{3'h0, 3'h1, 3'h3, 3'h5};
  logic [11:0]          ra[11] = '{12'h559, 12'h55A, 12'h561, 12'h562, 12'h563, 12'h564,
                                   12'h56E, 12'h56F, 12'h570, 12'h571, 12'h565};
  logic [7:0]           rv[11] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  aofc_output_format #(.SAMPLE_W(W)) i_dut (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .sampleA(sampleA), .sampleB(sampleB), .flagsA(flagsA), .flagsB(flagsB),
    .overrangeEvent(overrangeEvent), .ctrlBitsPerSample(ctrlBitsPerSample),
    .sysrefPin(sysrefPin), .pllLockPin(pllLockPin), .wordA(wordA), .wordB(wordB),
    .laneRateLow(laneRateLow), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finishTest();
    if (errCount == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic busWr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // the note is queued first; the monitor pops it when the read data stand
  task automatic busRd(input logic [11:0] a, input logic [7:0] e);
    rdQueue.push_back(e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  // sysref is held high, so its synchroniser has long settled at 1
  function automatic logic pick(input logic [2:0] c, input aofc_flags_type f);
    case (c)
      `AOFC_SEL_OVR:    return f.overrange;
      `AOFC_SEL_FAST:   return f.fastDetect;
      `AOFC_SEL_SYSREF: return sysrefPin;
      default:          return 1'b0;
    endcase
  endfunction

  function automatic logic [W+2:0] fmtWord(input logic [W-1:0] s, input aofc_flags_type f);
    logic [W-1:0] d;
    d = (fm[1:0] == `AOFC_FMT_OFFSET) ? {~s[W-1], s[W-2:0]} : s;
    if (fm[`AOFC_BIT_INVERT])
      d = ~d;
    return {d, (ctrlBitsPerSample == 2'h3) & pick(c1[2:0], f), 1'b0,
            (ctrlBitsPerSample != 2'h0) & pick(c2[2:0], f)};
  endfunction

  task automatic drive();
    logic [W-1:0]   a, b;
    aofc_flags_type fa, fb;
    a = W'($random(seed));
    b = W'($random(seed));
    fa = aofc_flags_type'(2'($random(seed)));
    fb = aofc_flags_type'(2'($random(seed)));
    wQueue.push_back(sw[0] ? {fmtWord(b, fb), fmtWord(a, fa)}
                           : {fmtWord(a, fa), fmtWord(b, fb)});
    @(posedge clk);
    sampleA <= a;
    sampleB <= b;
    flagsA <= fa;
    flagsB <= fb;
    chkW <= 1'b1;
    @(posedge clk);
    chkW <= 1'b0;
  endtask

////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rdLast)
      chk("rdata", 34'(rdQueue.pop_front()), 34'(rdata));
    if (wLast)
      chk("words", wQueue.pop_front(), {wordA, wordB});
    rdLast <= bus.rd;
    wLast <= chkW;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errCount++;
    finishTest();
  end

  initial
  begin
    seed = 76637;
    bus = '0;
    {sampleA, sampleB, flagsA, flagsB, overrangeEvent, ctrlBitsPerSample} = '0;
    {chkW, rdLast, wLast, pllLockPin} = '0;
    sysrefPin = 1'b1;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      busRd(ra[i], rv[i]);
    for (int i = 0; i < 64; i++)
    begin
      c1 = {5'h0, codes[i % 4]};
      c2 = {5'h0, codes[(i / 4) % 4]};
      fm = {5'h0, i[4] ^ i[1], 1'b0, i[5] ^ i[0]};
      sw = {7'h0, i[3] ^ i[4]};
      busWr(`AOFC_ADDR_CBSEL1, c1);
      busWr(`AOFC_ADDR_CBSEL2, c2);
      busWr(`AOFC_ADDR_FORMAT, fm);
      busWr(`AOFC_ADDR_CHORDER, sw);
      ctrlBitsPerSample <= 2'(i / 16);
      busRd(`AOFC_ADDR_CHORDER, sw);
      repeat (2) drive();
    end
    @(posedge clk);
    overrangeEvent <= 8'hA5;
    @(posedge clk);
    overrangeEvent <= 8'h00;
    busRd(`AOFC_ADDR_ORSTAT, 8'hA5);
    busRd(`AOFC_ADDR_IRQSTAT, 8'h01);
    busWr(`AOFC_ADDR_ORCLR, 8'h05);
    // a write to a read-only byte must leave the sticky bits alone
    busWr(`AOFC_ADDR_ORSTAT, 8'hFF);
    busRd(`AOFC_ADDR_ORSTAT, 8'hA0);
    busRd(`AOFC_ADDR_ORCLR, 8'h05);
    busWr(`AOFC_ADDR_IRQMASK, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq", 34'(1), 34'(irq));
    busWr(`AOFC_ADDR_IRQMASK, 8'h00);
    repeat (2) @(negedge clk);
    chk("irq", 34'(0), 34'(irq));
    busWr(`AOFC_ADDR_IRQMASK, 8'h03);
    busWr(`AOFC_ADDR_IRQSTAT, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq", 34'(0), 34'(irq));
    pllLockPin <= 1'b1;
    repeat (4) @(posedge clk);
    busRd(`AOFC_ADDR_LOCK, 8'h80);
    pllLockPin <= 1'b0;
    repeat (4) @(posedge clk);
    busRd(`AOFC_ADDR_LOCK, 8'h00);
    busRd(`AOFC_ADDR_IRQSTAT, 8'h02);
    repeat (2) @(negedge clk);
    chk("irq", 34'(1), 34'(irq));
    busWr(`AOFC_ADDR_LANERATE, 8'h10);
    repeat (2) @(negedge clk);
    chk("laneRateLow", 34'(1), 34'(laneRateLow));
    busRd(`AOFC_ADDR_LANERATE, 8'h10);
    repeat (4) @(posedge clk);
    finishTest();
  end
endmodule
